// *** lhcsr_pkg.sv ***
// Purpose: constants for the fallback configuration and soft reset slice
// Assumes: 8-bit register data, 6-bit register offsets
// Notes:   offsets and reset values shared by design and tests
`default_nettype none
package lhcsr_pkg;
    // -------------------------------------------------------------------
    // register offsets
    // -------------------------------------------------------------------
    localparam logic [5:0] PWM_LOW_OFS   = 6'h2A;
    localparam logic [5:0] PWM_HIGH_OFS  = 6'h2B;
    localparam logic [5:0] CH1_TON_OFS   = 6'h2C;
    localparam logic [5:0] CH2_TON_OFS   = 6'h2D;
    localparam logic [5:0] SOFT_RST_OFS  = 6'h2E;

    // -------------------------------------------------------------------
    // field layout and reset values
    // -------------------------------------------------------------------
    localparam int         PWM_HIGH_W    = 2;
    localparam int         TON_W         = 6;
    localparam logic [7:0] PWM_LOW_RST   = 8'h00;
    localparam logic [1:0] PWM_HIGH_RST  = 2'h0;
    localparam logic [5:0] TON_RST       = 6'h07;
    localparam logic       WDOG_EN_RST   = 1'b0;

    // -------------------------------------------------------------------
    // soft reset command codes
    // -------------------------------------------------------------------
    localparam logic [7:0] CMD_RST_WDOFF = 8'hC3;
    localparam logic [7:0] CMD_RST_WDON  = 8'hD4;

    localparam int         WDTO_W        = 2;
endpackage
`default_nettype wire

// *** lhcsr_top.sv ***
// Purpose: fallback pwm width, fallback on-time and soft reset command registers
// Assumes: serial interface already decoded into single-cycle register accesses
// Notes:   read data and all outputs are registered
//
// Notes on behaviour
// - 0x2A holds pwm width bits 7-0, reset zero
// - 0x2B bits 1-0 hold width 9-8; rest zero
// - 0x2C six-bit ch1 on-time, reset 0x07
// - 0x2D six-bit ch2 on-time, reset 0x07
// - 0x2E write-only command, reads return zero
// - 0xC3 restores defaults, disables watchdog
// - 0xC3 in stand-alone: state machines to LOAD
// - 0xD4 restores defaults, enables watchdog
// - stand-alone 0xD4 after flags cleared: to DETECT
// - soft reset never touches power-cycle flag
`timescale 1ns/1ps
`default_nettype none
module lhcsr_top
    import lhcsr_pkg::*;
(
    input  wire logic                          clk,
    input  wire logic                          arst_n,
    input  wire logic                          regWrEn,
    input  wire logic                          regRdEn,
    input  wire logic [5:0]                    regAddr,
    input  wire logic [7:0]                    regWrData,
    input  wire logic                          standAlone,
    input  wire logic [lhcsr_pkg::WDTO_W-1:0]  watchdogTimeoutFlags,
    output logic      [7:0]                    regRdData,
    output logic                               regRdValid,
    output logic      [9:0]                    ch2FallbackPwmWidth,
    output logic      [lhcsr_pkg::TON_W-1:0]   ch1FallbackOnTime,
    output logic      [lhcsr_pkg::TON_W-1:0]   ch2FallbackOnTime,
    output logic                               watchdogEnable,
    output logic                               softResetPulse,
    output logic                               enterLoadPulse,
    output logic                               enterDetectPulse
);
    import lhcsr_pkg::*;

    // -------------------------------------------------------------------
    // reset release
    // -------------------------------------------------------------------
    logic rstMeta_q;
    logic rstSync_q;
    logic rst_n;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rstMeta_q <= 1'b0;
            rstSync_q <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstSync_q <= rstMeta_q;
        end
    end
    assign rst_n = rstSync_q;

    // -------------------------------------------------------------------
    // command decode
    // -------------------------------------------------------------------
    logic cmdWrite;
    logic cmdWdOff;
    logic cmdWdOn;
    logic cmdAny;

    assign cmdWrite = regWrEn && (regAddr == SOFT_RST_OFS);
    assign cmdWdOff = cmdWrite && (regWrData == CMD_RST_WDOFF);
    assign cmdWdOn  = cmdWrite && (regWrData == CMD_RST_WDON);
    assign cmdAny   = cmdWdOff || cmdWdOn;

    // -------------------------------------------------------------------
    // configuration registers
    // -------------------------------------------------------------------
    logic [7:0]       pwmLow_q;
    logic [7:0]       pwmLow_d;
    logic [1:0]       pwmHigh_q;
    logic [1:0]       pwmHigh_d;
    logic [TON_W-1:0] ch1Ton_q;
    logic [TON_W-1:0] ch1Ton_d;
    logic [TON_W-1:0] ch2Ton_q;
    logic [TON_W-1:0] ch2Ton_d;
    logic             wdogEn_q;
    logic             wdogEn_d;

    always_comb begin
        pwmLow_d  = pwmLow_q;
        pwmHigh_d = pwmHigh_q;
        ch1Ton_d  = ch1Ton_q;
        ch2Ton_d  = ch2Ton_q;
        wdogEn_d  = wdogEn_q;
        if (cmdAny) begin
            // restore defaults; power-cycle flag lives elsewhere
            pwmLow_d  = PWM_LOW_RST;
            pwmHigh_d = PWM_HIGH_RST;
            ch1Ton_d  = TON_RST;
            ch2Ton_d  = TON_RST;
            wdogEn_d  = cmdWdOn;
        end else if (regWrEn) begin
            case (regAddr)
                PWM_LOW_OFS:  pwmLow_d  = regWrData;
                PWM_HIGH_OFS: pwmHigh_d = regWrData[PWM_HIGH_W-1:0];
                CH1_TON_OFS:  ch1Ton_d  = regWrData[TON_W-1:0];
                CH2_TON_OFS:  ch2Ton_d  = regWrData[TON_W-1:0];
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pwmLow_q  <= PWM_LOW_RST;
            pwmHigh_q <= PWM_HIGH_RST;
            ch1Ton_q  <= TON_RST;
            ch2Ton_q  <= TON_RST;
            wdogEn_q  <= WDOG_EN_RST;
        end else begin
            pwmLow_q  <= pwmLow_d;
            pwmHigh_q <= pwmHigh_d;
            ch1Ton_q  <= ch1Ton_d;
            ch2Ton_q  <= ch2Ton_d;
            wdogEn_q  <= wdogEn_d;
        end
    end

    assign ch2FallbackPwmWidth = {pwmHigh_q, pwmLow_q};
    assign ch1FallbackOnTime   = ch1Ton_q;
    assign ch2FallbackOnTime   = ch2Ton_q;
    assign watchdogEnable      = wdogEn_q;

    // -------------------------------------------------------------------
    // command side effects
    // -------------------------------------------------------------------
    logic softRst_q;
    logic softRst_d;
    logic enLoad_q;
    logic enLoad_d;
    logic enDetect_q;
    logic enDetect_d;

    always_comb begin
        softRst_d  = cmdAny;
        enLoad_d   = cmdWdOff && standAlone;
        enDetect_d = cmdWdOn && standAlone && (watchdogTimeoutFlags == '0);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            softRst_q  <= 1'b0;
            enLoad_q   <= 1'b0;
            enDetect_q <= 1'b0;
        end else begin
            softRst_q  <= softRst_d;
            enLoad_q   <= enLoad_d;
            enDetect_q <= enDetect_d;
        end
    end

    assign softResetPulse   = softRst_q;
    assign enterLoadPulse   = enLoad_q;
    assign enterDetectPulse = enDetect_q;

    // -------------------------------------------------------------------
    // read path
    // -------------------------------------------------------------------
    logic [7:0] rdData_q;
    logic [7:0] rdData_d;
    logic       rdValid_q;
    logic       rdValid_d;

    always_comb begin
        rdValid_d = regRdEn;
        rdData_d  = 8'h00;
        if (regRdEn) begin
            case (regAddr)
                PWM_LOW_OFS:  rdData_d = pwmLow_q;
                PWM_HIGH_OFS: rdData_d = {6'h00, pwmHigh_q};
                CH1_TON_OFS:  rdData_d = {2'h0, ch1Ton_q};
                CH2_TON_OFS:  rdData_d = {2'h0, ch2Ton_q};
                SOFT_RST_OFS: rdData_d = 8'h00;
                default:      rdData_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdData_q  <= 8'h00;
            rdValid_q <= 1'b0;
        end else begin
            rdData_q  <= rdData_d;
            rdValid_q <= rdValid_d;
        end
    end

    assign regRdData  = rdData_q;
    assign regRdValid = rdValid_q;

    // -------------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_pwm_low_write: assert property (regWrEn && regAddr == PWM_LOW_OFS
        |=> ch2FallbackPwmWidth[7:0] == $past(regWrData))
        else $error("pwm low byte not stored");
    a_pwm_high_read: assert property (regRdEn && regAddr == PWM_HIGH_OFS
        |=> regRdValid && regRdData[7:2] == 6'h00
            && regRdData[1:0] == $past(ch2FallbackPwmWidth[9:8]))
        else $error("pwm high readback wrong");
    a_ch1_ton_write: assert property (regWrEn && regAddr == CH1_TON_OFS
        |=> ch1FallbackOnTime == $past(regWrData[5:0]))
        else $error("ch1 on-time not stored");
    a_ch2_ton_read: assert property (regRdEn && regAddr == CH2_TON_OFS
        |=> regRdData == {2'h0, $past(ch2FallbackOnTime)})
        else $error("ch2 on-time readback wrong");
    a_cmd_reads_zero: assert property (regRdEn && regAddr == SOFT_RST_OFS
        |=> regRdValid && regRdData == 8'h00)
        else $error("command register read not zero");
    a_wdoff_restore: assert property (cmdWdOff |=> !watchdogEnable
        && ch1FallbackOnTime == TON_RST && ch2FallbackPwmWidth == 10'h000
        && softResetPulse)
        else $error("0xC3 did not restore");
    a_load_return: assert property (cmdWdOff && standAlone |=> enterLoadPulse)
        else $error("load return missing");
    a_load_cause: assert property (enterLoadPulse
        |-> $past(cmdWdOff && standAlone))
        else $error("load return without cause");
    a_wdon_restore: assert property (cmdWdOn |=> watchdogEnable
        && ch2FallbackOnTime == TON_RST)
        else $error("0xD4 did not restore");
    a_detect_return: assert property (cmdWdOn && standAlone
        && watchdogTimeoutFlags == '0 |=> enterDetectPulse)
        else $error("detect return missing");
    a_detect_cause: assert property (enterDetectPulse
        |-> $past(cmdWdOn && standAlone && watchdogTimeoutFlags == '0))
        else $error("detect return without cause");
    a_other_cmd_inert: assert property (cmdWrite && !cmdAny
        |=> $stable(watchdogEnable) && $stable(ch2FallbackPwmWidth)
            && !softResetPulse && !enterLoadPulse && !enterDetectPulse)
        else $error("undefined command had effect");

    c_wdoff_standalone: cover property (cmdWdOff && standAlone);
    c_wdon_detect: cover property (enterDetectPulse);
    c_wdon_flags_set: cover property (cmdWdOn && standAlone && watchdogTimeoutFlags != '0);
    c_write_then_read: cover property (regWrEn && regAddr == PWM_HIGH_OFS ##1 regRdEn
        && regAddr == PWM_HIGH_OFS);
endmodule
`default_nettype wire

// *** lhcsr_host_model.sv ***
// Purpose: host controller model issuing decoded register accesses
// Assumes: one strobe per access, driven just after a rising edge
// Notes:   status read by the host clears the timeout flags
`timescale 1ns/1ps
`default_nettype none
module lhcsr_host_model (
    input  wire logic       clk,
    input  wire logic [7:0] regRdData,
    input  wire logic       regRdValid,
    output logic            regWrEn,
    output logic            regRdEn,
    output logic [5:0]      regAddr,
    output logic [7:0]      regWrData,
    output logic            standAlone,
    output logic [1:0]      watchdogTimeoutFlags
);
    initial begin
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        regAddr = 6'h00;
        regWrData = 8'h00;
        standAlone = 1'b0;
        watchdogTimeoutFlags = 2'h0;
    end
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        regWrEn <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWrEn <= 1'b0;
        regWrData <= ~d;
        #1;
    endtask
    task automatic rd(input logic [5:0] a, output logic [7:0] d, output logic v);
        @(posedge clk);
        regRdEn <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRdEn <= 1'b0;
        #1;
        d = regRdData;
        v = regRdValid;
    endtask
    task automatic setMode(input logic sa, input logic [1:0] f);
        @(posedge clk);
        standAlone <= sa;
        watchdogTimeoutFlags <= f;
    endtask
    // status read before the restart command clears the flags
    task automatic clrFlags;
        @(posedge clk);
        watchdogTimeoutFlags <= 2'h0;
    endtask
endmodule
`default_nettype wire

// *** tb.sv ***
// Purpose: self-checking bench for fallback config and soft reset
// Assumes: host model drives all register accesses
// Notes:   expectations built from package constants
`timescale 1ns/1ps
`default_nettype none
module tb;
    import lhcsr_pkg::*;
    logic       clk, arst_n, regWrEn, regRdEn, standAlone, regRdValid;
    logic [5:0] regAddr, ch1FallbackOnTime, ch2FallbackOnTime;
    logic [7:0] regWrData, regRdData;
    logic [1:0] watchdogTimeoutFlags;
    logic [9:0] ch2FallbackPwmWidth;
    logic       watchdogEnable, softResetPulse, enterLoadPulse, enterDetectPulse;
    int         errCount, totalChecks;
    lhcsr_top uut (.clk(clk), .arst_n(arst_n), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regAddr(regAddr), .regWrData(regWrData), .standAlone(standAlone),
        .watchdogTimeoutFlags(watchdogTimeoutFlags), .regRdData(regRdData),
        .regRdValid(regRdValid), .ch2FallbackPwmWidth(ch2FallbackPwmWidth),
        .ch1FallbackOnTime(ch1FallbackOnTime), .ch2FallbackOnTime(ch2FallbackOnTime),
        .watchdogEnable(watchdogEnable), .softResetPulse(softResetPulse),
        .enterLoadPulse(enterLoadPulse), .enterDetectPulse(enterDetectPulse));
    lhcsr_host_model host (.clk(clk), .regRdData(regRdData), .regRdValid(regRdValid),
        .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData),
        .standAlone(standAlone), .watchdogTimeoutFlags(watchdogTimeoutFlags));
    // -------------------------------------------------------------------
    // checking tasks
    // -------------------------------------------------------------------
    task automatic finalReport;
        $display("checks %0d errors %0d", totalChecks, errCount);
        if (errCount == 0 && totalChecks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        totalChecks++;
        if (got !== exp) begin
            errCount++;
            $display("FAIL t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rdChk(input logic [5:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic       v;
        host.rd(a, d, v);
        chk({2'h0, d}, {2'h0, exp});
        chk({9'h0, v}, 10'h001);
        @(posedge clk);
        #1;
        chk({1'b0, regRdValid, regRdData}, 10'h000);
    endtask
    task automatic outChk(input logic [9:0] w, input logic [5:0] t, input logic wd);
        chk(ch2FallbackPwmWidth, w);
        chk({4'h0, ch1FallbackOnTime}, {4'h0, t});
        chk({4'h0, ch2FallbackOnTime}, {4'h0, t});
        chk({9'h0, watchdogEnable}, {9'h0, wd});
    endtask
    task automatic fill;
        for (int i = 0; i < 4; i++) begin
            host.wr(PWM_LOW_OFS + 6'(i), 8'hFF);
        end
    endtask
    task automatic cmd(input logic [7:0] c, input logic s, input logic l, input logic d);
        host.wr(SOFT_RST_OFS, c);
        chk({7'h0, softResetPulse, enterLoadPulse, enterDetectPulse}, {7'h0, s, l, d});
        @(posedge clk);
        #1;
        chk({7'h0, softResetPulse, enterLoadPulse, enterDetectPulse}, 10'h000);
    endtask
    // -------------------------------------------------------------------
    // clock, watchdog and test sequence
    // -------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        #40000;
        errCount++;
        finalReport;
    end
    initial begin
        arst_n = 1'b0;
        errCount = 0;
        totalChecks = 0;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        outChk(10'h000, TON_RST, WDOG_EN_RST);
        rdChk(PWM_LOW_OFS, PWM_LOW_RST);
        rdChk(CH2_TON_OFS, {2'h0, TON_RST});
        fill;
        outChk(10'h3FF, 6'h3F, WDOG_EN_RST);
        rdChk(PWM_HIGH_OFS, 8'h03);
        rdChk(CH1_TON_OFS, 8'h3F);
        rdChk(SOFT_RST_OFS, 8'h00);
        rdChk(6'h29, 8'h00);
        cmd(8'h5A, 1'b0, 1'b0, 1'b0);
        outChk(10'h3FF, 6'h3F, WDOG_EN_RST);
        host.wr(PWM_LOW_OFS, 8'h5A);
        chk(ch2FallbackPwmWidth, 10'h35A);
        host.wr(CH2_TON_OFS, 8'hC5);
        chk({4'h0, ch2FallbackOnTime}, 10'h005);
        chk({4'h0, ch1FallbackOnTime}, 10'h03F);
        rdChk(CH2_TON_OFS, 8'h05);
        host.setMode(1'b1, 2'h1);
        cmd(CMD_RST_WDON, 1'b1, 1'b0, 1'b0);
        outChk(10'h000, TON_RST, 1'b1);
        host.clrFlags;
        fill;
        cmd(CMD_RST_WDON, 1'b1, 1'b0, 1'b1);
        outChk(10'h000, TON_RST, 1'b1);
        fill;
        cmd(CMD_RST_WDOFF, 1'b1, 1'b1, 1'b0);
        outChk(10'h000, TON_RST, 1'b0);
        rdChk(PWM_HIGH_OFS, 8'h00);
        host.setMode(1'b0, 2'h0);
        cmd(CMD_RST_WDON, 1'b1, 1'b0, 1'b0);
        cmd(CMD_RST_WDOFF, 1'b1, 1'b0, 1'b0);
        fill;
        @(posedge clk);
        arst_n <= 1'b0;
        #1;
        outChk(10'h000, TON_RST, WDOG_EN_RST);
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rdChk(CH1_TON_OFS, {2'h0, TON_RST});
        finalReport;
    end
endmodule
`default_nettype wire
